// >>> pms_pkg.sv
// Constants and types shared by the power mode sequencer
package pms_pkg;
   // Operating modes of the sequencer
   typedef enum logic [3:0] {
      PMS_NO_POWER, PMS_LOAD, PMS_HOTPLUG, PMS_ENABLE, PMS_SEQ,
      PMS_RESET, PMS_PG_CHECK, PMS_NORMAL, PMS_SLEEP
   } pms_mode_t;
   // Why the sleep mode was entered
   typedef enum logic [1:0] {
      PMS_WHY_NONE, PMS_WHY_THERMAL, PMS_WHY_LOWSYS, PMS_WHY_OTHER
   } pms_why_t;
   // Monitored supplies: buck_one, buck_two, white_led_boost, five LDOs
   localparam int PMS_NSUP = 8;
   localparam int PMS_WLED_BIT = 2;
   // Number of monitored status parameters for the interrupt logic
   localparam int PMS_NSTAT = 12;
   // Steps in the supply sequence table
   localparam int PMS_NSTEP = 8;
   localparam int PMS_STEP_W = 3;
   // Delay field width of one step, in bits; the delay counts clocks
   localparam int PMS_DLY_W = 16;
   // Power-up defaults
   localparam logic [PMS_NSUP-1:0] PMS_PG_MASK_RST = 8'hFF;
   localparam logic [PMS_NSTAT-1:0] PMS_INT_MASK_RST = 12'h000;
   localparam logic [PMS_NSUP-1:0] PMS_SUP_EN_RST = 8'h00;
   localparam logic [PMS_NSUP-1:0] PMS_SUP_DEF_BUCKS = 8'h03;
   localparam logic [2:0] PMS_GPIO_DIR_RST = 3'h0;
   // Interrupt pulse setup: open-drain released, output enable high
   localparam logic PMS_OE_OFF = 1'b1;
endpackage : pms_pkg

// >>> pms_seq_steps.sv
// Supply turn-on stepper driven by the sequence table
`timescale 1ns/1ps
`default_nettype none
module pms_seq_steps
   import pms_pkg::*;
#(
   parameter int NSUP = PMS_NSUP,
   parameter int NSTEP = PMS_NSTEP
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic abort,
   input wire logic [NSTEP*PMS_STEP_W-1:0] step_sup,
   input wire logic [NSTEP*PMS_DLY_W-1:0] step_dly,
   input wire logic [NSUP-1:0] sup_allowed,
   output logic [NSUP-1:0] sup_on,
   output logic done
);
   logic busy_q;
   logic [$clog2(NSTEP+1)-1:0] idx_q;
   logic [PMS_DLY_W-1:0] cnt_q;
   logic [NSUP-1:0] on_q;
   logic done_q;
   logic [PMS_STEP_W-1:0] cur_sup;
   logic [PMS_DLY_W-1:0] cur_dly;

   // Current step fields
   always_comb begin
      cur_sup = step_sup[idx_q[PMS_STEP_W-1:0]*PMS_STEP_W +: PMS_STEP_W];
      cur_dly = step_dly[idx_q[PMS_STEP_W-1:0]*PMS_DLY_W +: PMS_DLY_W];
   end

   // Walk the steps: wait the delay, then switch the step's supply on
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
         idx_q <= '0;
         cnt_q <= '0;
         on_q <= '0;
         done_q <= 1'b0;
      end else if (abort) begin
         // Fault or sleep drops every supply at once
         busy_q <= 1'b0;
         on_q <= '0;
         done_q <= 1'b0;
      end else if (start && !busy_q) begin
         busy_q <= 1'b1;
         idx_q <= '0;
         cnt_q <= '0;
         on_q <= '0;
         done_q <= 1'b0;
      end else if (busy_q) begin
         done_q <= 1'b0;
         if (cnt_q >= cur_dly) begin
            // Supplies disabled by software are skipped, order kept
            if (sup_allowed[cur_sup]) begin
               on_q[cur_sup] <= 1'b1;
            end
            cnt_q <= '0;
            if (idx_q == ($clog2(NSTEP+1))'(NSTEP-1)) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               idx_q <= idx_q + 1'b1;
            end
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end else begin
         done_q <= 1'b0;
      end
   end

   assign sup_on = on_q;
   assign done = done_q;
endmodule : pms_seq_steps
`default_nettype wire

// >>> pms_sequencer.sv
// Operating mode state machine of the power management device
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - supply fault low rail, boost overvoltage
// - unmasked power-good fault: sleep or restart
// - power-good comparators blanked during power-up
// - thermal fault enters sleep, fixed threshold
// - thermal sleep exits only after full power cycle
// - hardware reset pin low pulses host reset
// - software reset bit pulses host reset
// - writable interrupt and power-good masks
// - interrupt on any unmasked status change in normal mode
// - all inputs under lockout keeps everything off
// - load register defaults once rails active
// - enable power path, clear loaded flag, debounce
// - debounce timer blocks sleep while running
// - enable: host reset low, interrupt released
// - wait system voltage, then sequence supplies
// - turn supplies on per stored sequence
// - sequencing done starts reset timer
// - reset state holds host reset, I2C reset
// - timer expiry pulls interrupt low, check
// - check: fault goes sleep, else normal
// - normal-mode faults, resets and sleep request
module pms_sequencer
   import pms_pkg::*;
#(
   parameter int NSUP = PMS_NSUP,
   parameter int NSTAT = PMS_NSTAT,
   parameter int NSTEP = PMS_NSTEP
) (
   input wire logic mclk,
   input wire logic reset_n,
   // Undervoltage lockout comparators, one per input source
   input wire logic adapter_above_uvlo,
   input wire logic usb_above_uvlo,
   input wire logic battery_above_uvlo,
   // Internal rails are up
   input wire logic rails_active,
   // Low system comparator on system_voltage_sense
   input wire logic system_voltage_ok,
   // Junction temperature above fixed internal threshold
   input wire logic thermal_fault,
   // Per supply: below 90% of target, or boost over voltage
   input wire logic [NSUP-1:0] supply_fault_raw,
   // Expiry of insertion_debounce_timer and of reset timer
   input wire logic insertion_debounce_timer_done,
   input wire logic reset_timer_done,
   // Hardware reset pin, after its own deglitch
   input wire logic hw_reset_n_in,
   // Host register bits
   input wire logic soft_reset_req,
   input wire logic soft_sleep_req,
   input wire logic [NSUP-1:0] pg_mask_wr,
   input wire logic pg_mask_we,
   input wire logic [NSTAT-1:0] int_mask_wr,
   input wire logic int_mask_we,
   input wire logic [NSUP-1:0] supply_enable_wr,
   input wire logic supply_enable_we,
   // Other monitored status bits (charger, ADC, inputs)
   input wire logic [NSTAT-NSUP-3:0] other_status,
   // Sequence table from non-volatile storage
   input wire logic [NSTEP*PMS_STEP_W-1:0] nv_step_sup,
   input wire logic [NSTEP*PMS_DLY_W-1:0] nv_step_dly,
   // Outputs
   output logic host_reset_n_out,
   output logic int_n_out,
   output logic int_n_oe,
   output logic i2c_engine_reset,
   output logic defaults_loaded_n,
   output logic power_path_en,
   output logic insertion_debounce_start,
   output logic reset_timer_start,
   output logic pg_comparators_en,
   output logic [NSUP-1:0] supply_on,
   output logic [NSUP-1:0] pg_mask,
   output logic [NSTAT-1:0] int_mask,
   output logic [NSUP-1:0] supply_fault,
   output logic [2:0] gpio_dir,
   output logic adc_led_off,
   output pms_pkg::pms_mode_t mode
);
   // Two-stage synchronisers for asynchronous inputs
   localparam int NSYNC = 9 + NSUP;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [NSYNC-1:0] raw_in;
   logic ac_s, usb_s, bat_s, rails_s, sys_s, therm_s, hw_rst_n_s;
   logic dbt_done_s, rst_done_s;
   logic [NSUP-1:0] sup_fault_s;

   pms_mode_t mode_q; // Current operating mode
   pms_why_t why_q; // Cause of the present sleep
   logic dbt_running_q; // Debounce timer still running
   logic hw_rst_seen_q; // Hardware reset pin went low
   logic [NSUP-1:0] pg_mask_q;
   logic [NSTAT-1:0] int_mask_q;
   logic [NSUP-1:0] sup_en_q; // Software supply enables
   logic loaded_n_q;
   logic int_n_q;
   logic int_oe_q;
   logic [NSTAT-1:0] stat_prev_q;
   logic [NSTAT-1:0] stat_now;
   logic any_power;
   logic pg_fault;
   logic seq_start, seq_abort, seq_done;
   logic stat_change;
   logic inputs_seen_off_q; // Input power removed during sleep
   logic [2:0] gpio_dir_q;

   // Synchronise every pin and analog comparator before use
   assign raw_in = {supply_fault_raw, hw_reset_n_in, reset_timer_done,
                    insertion_debounce_timer_done, thermal_fault,
                    system_voltage_ok, rails_active, battery_above_uvlo,
                    usb_above_uvlo, adapter_above_uvlo};
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end
   assign ac_s = sync2_q[0];
   assign usb_s = sync2_q[1];
   assign bat_s = sync2_q[2];
   assign rails_s = sync2_q[3];
   assign sys_s = sync2_q[4];
   assign therm_s = sync2_q[5];
   assign dbt_done_s = sync2_q[6];
   assign rst_done_s = sync2_q[7];
   assign hw_rst_n_s = sync2_q[8];
   assign sup_fault_s = sync2_q[NSYNC-1:9];

   // Any source above lockout lets the device power up
   assign any_power = ac_s | usb_s | bat_s;

   // Fault only counts when comparators run and supply unmasked
   assign pg_fault = pg_comparators_en && |(sup_fault_s & ~pg_mask_q);

   // Supply stepper
   assign seq_start = (mode_q == PMS_SEQ) && !seq_done;
   assign seq_abort = (mode_q == PMS_NO_POWER) || (mode_q == PMS_SLEEP)
                      || (mode_q == PMS_ENABLE);
   pms_seq_steps #(
      .NSUP(NSUP),
      .NSTEP(NSTEP)
   ) u_steps (
      .mclk(mclk),
      .reset_n(reset_n),
      .start(seq_start),
      .abort(seq_abort),
      .step_sup(nv_step_sup),
      .step_dly(nv_step_dly),
      .sup_allowed(sup_en_q),
      .sup_on(supply_on),
      .done(seq_done)
   );

   // Main mode machine
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= PMS_NO_POWER;
         why_q <= PMS_WHY_NONE;
      end else if (!any_power) begin
         // Lockout wins from every mode
         mode_q <= PMS_NO_POWER;
         why_q <= PMS_WHY_NONE;
      end else begin
         unique case (mode_q)
            PMS_NO_POWER: begin
               mode_q <= PMS_LOAD;
            end
            PMS_LOAD: begin
               if (rails_s) begin
                  mode_q <= PMS_HOTPLUG;
               end
            end
            PMS_HOTPLUG: begin
               mode_q <= PMS_ENABLE;
            end
            PMS_ENABLE: begin
               if (sys_s) begin
                  mode_q <= PMS_SEQ;
               end
            end
            PMS_SEQ: begin
               if (seq_done) begin
                  mode_q <= PMS_RESET;
               end
            end
            PMS_RESET: begin
               if (rst_done_s) begin
                  mode_q <= PMS_PG_CHECK;
               end
            end
            PMS_PG_CHECK: begin
               // Comparators came on when this state began
               if (pg_fault && !dbt_running_q) begin
                  mode_q <= PMS_SLEEP;
                  why_q <= PMS_WHY_OTHER;
               end else if (!pg_fault) begin
                  mode_q <= PMS_NORMAL;
               end
            end
            PMS_NORMAL: begin
               // Thermal first: its sleep has the hardest exit
               if (therm_s && !dbt_running_q) begin
                  mode_q <= PMS_SLEEP;
                  why_q <= PMS_WHY_THERMAL;
               end else if (!sys_s && !dbt_running_q) begin
                  mode_q <= PMS_SLEEP;
                  why_q <= PMS_WHY_LOWSYS;
               end else if (pg_fault) begin
                  mode_q <= PMS_NO_POWER;
               end else if (soft_reset_req || hw_rst_seen_q) begin
                  mode_q <= PMS_RESET;
               end else if (soft_sleep_req && !dbt_running_q) begin
                  mode_q <= PMS_SLEEP;
                  why_q <= PMS_WHY_OTHER;
               end
            end
            PMS_SLEEP: begin
               // Thermal sleep leaves only through lockout
               if (why_q != PMS_WHY_THERMAL && inputs_seen_off_q
                   && (ac_s || usb_s)) begin
                  mode_q <= PMS_ENABLE;
                  why_q <= PMS_WHY_NONE;
               end
            end
            default: begin
               mode_q <= PMS_NO_POWER;
            end
         endcase
      end
   end

   // Track removal of input power while asleep
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         inputs_seen_off_q <= 1'b0;
      end else if (mode_q != PMS_SLEEP) begin
         inputs_seen_off_q <= 1'b0;
      end else if (!ac_s && !usb_s) begin
         inputs_seen_off_q <= 1'b1;
      end
   end

   // Debounce timer runs from hotplug until expiry
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dbt_running_q <= 1'b0;
      end else if (mode_q == PMS_HOTPLUG) begin
         dbt_running_q <= 1'b1;
      end else if (dbt_done_s) begin
         dbt_running_q <= 1'b0;
      end
   end

   // Hardware reset: pin low in normal is latched, reset state follows next cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         hw_rst_seen_q <= 1'b0;
      end else if (mode_q != PMS_NORMAL) begin
         hw_rst_seen_q <= 1'b0;
      end else if (!hw_rst_n_s) begin
         hw_rst_seen_q <= 1'b1;
      end
   end

   // Masks and software enables, defaults on load
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pg_mask_q <= PMS_PG_MASK_RST;
         int_mask_q <= PMS_INT_MASK_RST;
         sup_en_q <= PMS_SUP_EN_RST;
         gpio_dir_q <= PMS_GPIO_DIR_RST;
      end else if (mode_q == PMS_LOAD) begin
         pg_mask_q <= PMS_PG_MASK_RST;
         int_mask_q <= PMS_INT_MASK_RST;
         sup_en_q <= ~PMS_SUP_EN_RST; // Buck one and two among them
         gpio_dir_q <= PMS_GPIO_DIR_RST;
      end else begin
         if (pg_mask_we) begin
            pg_mask_q <= pg_mask_wr;
         end
         if (int_mask_we) begin
            int_mask_q <= int_mask_wr;
         end
         if (supply_enable_we) begin
            // Buck one and two are forced on by default only at load
            sup_en_q <= supply_enable_wr;
         end
      end
   end

   // Defaults-loaded flag goes low once load completes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         loaded_n_q <= 1'b1;
      end else if (mode_q == PMS_NO_POWER) begin
         loaded_n_q <= 1'b1;
      end else if (mode_q == PMS_LOAD && rails_s) begin
         loaded_n_q <= 1'b0;
      end
   end

   // Status change detector for the interrupt line
   assign stat_now = {other_status, therm_s, sys_s, sup_fault_s};
   assign stat_change = |((stat_now ^ stat_prev_q) & ~int_mask_q);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stat_prev_q <= '0;
      end else begin
         stat_prev_q <= stat_now;
      end
   end

   // Interrupt pin: released in enable, pulled at reset end
   // Stays low until the next enable or no power; host reads status to learn why
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         int_n_q <= 1'b1;
         int_oe_q <= PMS_OE_OFF;
      end else if (mode_q == PMS_ENABLE || mode_q == PMS_NO_POWER) begin
         int_n_q <= 1'b1;
         int_oe_q <= PMS_OE_OFF;
      end else if (mode_q == PMS_RESET && rst_done_s) begin
         int_n_q <= 1'b0;
         int_oe_q <= ~PMS_OE_OFF;
      end else if (mode_q == PMS_NORMAL && stat_change) begin
         int_n_q <= 1'b0;
         int_oe_q <= ~PMS_OE_OFF;
      end
   end

   // Host reset held low outside check and normal
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         host_reset_n_out <= 1'b0;
      end else if (mode_q == PMS_NORMAL && !hw_rst_n_s) begin
         host_reset_n_out <= 1'b0;
      end else begin
         host_reset_n_out <= (mode_q == PMS_PG_CHECK) ||
                             (mode_q == PMS_NORMAL);
      end
   end

   // Misc outputs
   assign mode = mode_q;
   assign i2c_engine_reset = ~host_reset_n_out;
   assign defaults_loaded_n = loaded_n_q;
   assign power_path_en = (mode_q != PMS_NO_POWER) &&
                          (mode_q != PMS_LOAD);
   assign insertion_debounce_start = (mode_q == PMS_HOTPLUG);
   assign reset_timer_start = (mode_q == PMS_SEQ) && seq_done;
   // Comparators off until check, blanking power-up
   assign pg_comparators_en = (mode_q == PMS_PG_CHECK) ||
                              (mode_q == PMS_NORMAL);
   assign pg_mask = pg_mask_q;
   assign int_mask = int_mask_q;
   assign supply_fault = sup_fault_s;
   assign int_n_out = int_n_q;
   assign int_n_oe = int_oe_q;
   assign gpio_dir = gpio_dir_q;
   assign adc_led_off = (mode_q != PMS_NORMAL);
endmodule : pms_sequencer
`default_nettype wire

// >>> pms_sequencer_checker.sv
// Port checker for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module pms_sequencer_checker
   import pms_pkg::*;
#(
   parameter int NSUP = PMS_NSUP,
   parameter int NSTAT = PMS_NSTAT
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic adapter_above_uvlo,
   input wire logic usb_above_uvlo,
   input wire logic battery_above_uvlo,
   input wire logic thermal_fault,
   input wire logic insertion_debounce_timer_done,
   input wire logic host_reset_n_out,
   input wire logic int_n_out,
   input wire logic int_n_oe,
   input wire logic i2c_engine_reset,
   input wire logic defaults_loaded_n,
   input wire logic power_path_en,
   input wire logic reset_timer_start,
   input wire logic pg_comparators_en,
   input wire logic [NSUP-1:0] pg_mask,
   input wire logic [NSTAT-1:0] int_mask,
   input wire logic [NSUP-1:0] supply_fault,
   input wire logic [2:0] gpio_dir,
   input wire logic adc_led_off,
   input wire pms_pkg::pms_mode_t mode
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // All sources under lockout
   logic no_src;
   assign no_src = !(adapter_above_uvlo | usb_above_uvlo | battery_above_uvlo);
   AST_UVLO_OFF:
      assert property (no_src [*4] |-> ##[0:3] mode == PMS_NO_POWER)
      else $error("up with no source");
   AST_DEFAULTS:
      assert property (mode == PMS_HOTPLUG |-> pg_mask == PMS_PG_MASK_RST &&
         int_mask == PMS_INT_MASK_RST && gpio_dir == 3'h0 && adc_led_off)
      else $error("defaults not loaded");
   AST_LOADED:
      assert property (mode == PMS_ENABLE |-> !defaults_loaded_n && power_path_en)
      else $error("load flag or path");
   // Registered outputs lag the mode by one edge
   AST_ENABLE_OUT:
      assert property (mode == PMS_ENABLE && $past(mode) == PMS_ENABLE
         |-> !host_reset_n_out && int_n_oe && !pg_comparators_en)
      else $error("enable outputs");
   AST_BLANK:
      assert property (mode inside {PMS_LOAD, PMS_HOTPLUG, PMS_ENABLE,
         PMS_SEQ, PMS_RESET} |-> !pg_comparators_en)
      else $error("not blanked");
   AST_TIMER_START:
      assert property (mode == PMS_RESET && $past(mode) == PMS_SEQ
         |-> reset_timer_start || $past(reset_timer_start))
      else $error("no timer start");
   AST_RESET_HOLD:
      assert property (mode == PMS_RESET && $past(mode) == PMS_RESET
         |-> !host_reset_n_out)
      else $error("host released");
   AST_I2C_RST:
      assert property (i2c_engine_reset == !host_reset_n_out)
      else $error("i2c reset");
   AST_CHECK_INT:
      assert property (mode == PMS_PG_CHECK |-> ##[0:2] !int_n_oe && !int_n_out)
      else $error("no interrupt");
   AST_CHECK_PG:
      assert property (mode == PMS_PG_CHECK |-> pg_comparators_en)
      else $error("check comps off");
   AST_PG_FAULT:
      assert property (mode == PMS_NORMAL && |(supply_fault & ~pg_mask)
         |-> ##[1:4] mode == PMS_NO_POWER)
      else $error("fault ignored");
   // Debounce still running may legally hold off sleep
   AST_THERMAL:
      assert property ((mode == PMS_NORMAL && thermal_fault &&
         insertion_debounce_timer_done) [*3] |-> ##[0:2] mode == PMS_SLEEP)
      else $error("thermal fault ignored");
   COV_NORMAL: cover property (mode == PMS_NORMAL);
   COV_SLEEP: cover property (mode == PMS_SLEEP);
   COV_SOFT: cover property ($past(mode) == PMS_NORMAL && mode == PMS_RESET);
   COV_PGOFF: cover property ($past(mode) == PMS_NORMAL && mode == PMS_NO_POWER);
endmodule : pms_sequencer_checker
bind pms_sequencer pms_sequencer_checker #(.NSUP(NSUP), .NSTAT(NSTAT)) u_chk (
   .mclk, .reset_n, .adapter_above_uvlo, .usb_above_uvlo, .battery_above_uvlo,
   .thermal_fault, .insertion_debounce_timer_done, .host_reset_n_out,
   .int_n_out, .int_n_oe, .i2c_engine_reset, .defaults_loaded_n,
   .power_path_en, .reset_timer_start, .pg_comparators_en, .pg_mask,
   .int_mask, .supply_fault, .gpio_dir, .adc_led_off, .mode
);
`default_nettype wire

// >>> pms_host_model.sv
// Host processor model: soft reset bit and mask register writes
`timescale 1ns/1ps
`default_nettype none
module pms_host_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic host_reset_n_out,
   input wire logic [1:0] cmd,
   input wire logic [11:0] wdata,
   input wire logic go,
   output logic soft_reset_req,
   output logic [11:0] wr_data,
   output logic [2:0] we,
   output logic busy
);
   // A command waits until the device lets the host run
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'h0;
         we <= 3'h0;
         wr_data <= 12'h000;
      end else begin
         we <= 3'h0;
         // Data toggles outside strobes
         wr_data <= ~wr_data;
         if (go) begin
            busy <= 1'h1;
         end else if (busy && host_reset_n_out) begin
            busy <= 1'h0;
            wr_data <= wdata;
            if (cmd != 2'h0) begin
               we <= 3'h1 << (cmd - 2'h1);
            end
         end
      end
   end
   // Soft reset bit stays set until the host sees its reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         soft_reset_req <= 1'h0;
      end else if (!go && busy && host_reset_n_out && cmd == 2'h0) begin
         soft_reset_req <= 1'h1;
      end else if (!host_reset_n_out) begin
         soft_reset_req <= 1'h0;
      end
   end
endmodule : pms_host_model
`default_nettype wire

// >>> tb.sv
// Testbench for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pms_pkg::*;
   logic mclk = 1'h0;
   logic reset_n = 1'h0;
   logic adapter_above_uvlo = 1'h0, usb_above_uvlo = 1'h0;
   logic battery_above_uvlo = 1'h0, rails_active = 1'h0;
   logic system_voltage_ok = 1'h0, thermal_fault = 1'h0;
   logic [7:0] supply_fault_raw = 8'h00;
   logic insertion_debounce_timer_done = 1'h0;
   logic reset_timer_done = 1'h0;
   logic hw_reset_n_in = 1'h1;
   logic soft_sleep_req = 1'h0;
   logic [1:0] other_status = 2'h0;
   // Step i turns on supply 7-i
   logic [23:0] nv_step_sup = 24'h053977;
   logic [127:0] nv_step_dly = {8{16'h0002}};
   logic [1:0] cmd = 2'h0;
   logic [11:0] wdata = 12'h000;
   logic go = 1'h0;
   logic soft_reset_req, busy, host_reset_n_out, int_n_out, int_n_oe;
   logic i2c_engine_reset, defaults_loaded_n, power_path_en;
   logic insertion_debounce_start, reset_timer_start, pg_comparators_en;
   logic adc_led_off;
   logic [11:0] wr_data, int_mask;
   logic [2:0] we, gpio_dir;
   logic [7:0] supply_on, pg_mask, supply_fault;
   pms_mode_t mode;
   int failures = 0, checks = 0, cyc = 0;
   pms_sequencer u_dut (
      .mclk, .reset_n, .adapter_above_uvlo, .usb_above_uvlo,
      .battery_above_uvlo, .rails_active, .system_voltage_ok, .thermal_fault,
      .supply_fault_raw, .insertion_debounce_timer_done, .reset_timer_done,
      .hw_reset_n_in, .soft_reset_req, .soft_sleep_req,
      .pg_mask_wr(wr_data[7:0]), .pg_mask_we(we[0]), .int_mask_wr(wr_data),
      .int_mask_we(we[1]), .supply_enable_wr(wr_data[7:0]),
      .supply_enable_we(we[2]), .other_status, .nv_step_sup, .nv_step_dly,
      .host_reset_n_out, .int_n_out, .int_n_oe, .i2c_engine_reset,
      .defaults_loaded_n, .power_path_en, .insertion_debounce_start,
      .reset_timer_start, .pg_comparators_en, .supply_on, .pg_mask,
      .int_mask, .supply_fault, .gpio_dir, .adc_led_off, .mode
   );
   pms_host_model u_host (
      .mclk, .reset_n, .host_reset_n_out, .cmd, .wdata, .go,
      .soft_reset_req, .wr_data, .we, .busy
   );
   always #4 mclk = ~mclk;
   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         $display("[ERR] %0t run timed out", $time);
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'h1) begin
         failures++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk
   task automatic pos(input int k);
      repeat (k) @(posedge mclk);
   endtask : pos
   // Polls on falling edges
   task automatic wait_mode(input pms_mode_t m, input int lim);
      int n = 0;
      @(negedge mclk);
      while (mode !== m && n < lim) begin
         @(negedge mclk);
         n++;
      end
      chk(mode === m, "mode not reached");
   endtask : wait_mode
   task automatic host_cmd(input logic [1:0] c, input logic [11:0] d);
      int n = 0;
      pos(1);
      cmd <= c;
      wdata <= d;
      go <= 1'h1;
      pos(1);
      go <= 1'h0;
      pos(1);
      while (busy !== 1'h0 && n < 50) begin
         pos(1);
         n++;
      end
   endtask : host_cmd
   // Timer expiry ends the reset state
   task automatic leave_reset();
      pos(1);
      reset_timer_done <= 1'h1;
      wait_mode(PMS_NORMAL, 10);
      pos(1);
      reset_timer_done <= 1'h0;
   endtask : leave_reset
   task automatic power_off();
      pos(1);
      {supply_fault_raw, battery_above_uvlo, rails_active} <= 10'h000;
      {system_voltage_ok, insertion_debounce_timer_done} <= 2'h0;
      {adapter_above_uvlo, usb_above_uvlo} <= 2'h0;
      pos(20);
      @(negedge mclk);
      chk(mode === PMS_NO_POWER && supply_on === 8'h00, "not off");
   endtask : power_off
   task automatic power_up();
      int n = 0;
      pos(1);
      battery_above_uvlo <= 1'h1;
      wait_mode(PMS_LOAD, 10);
      pos(1);
      rails_active <= 1'h1;
      wait_mode(PMS_ENABLE, 20);
      pos(1);
      insertion_debounce_timer_done <= 1'h1;
      pos(10);
      @(negedge mclk);
      chk(mode === PMS_ENABLE && int_n_oe === 1'h1, "left enable");
      pos(1);
      system_voltage_ok <= 1'h1;
      wait_mode(PMS_SEQ, 10);
      while (mode === PMS_SEQ && n < 200) begin
         chk(((supply_on << 1) & ~supply_on) === 8'h00, "order");
         @(negedge mclk);
         n++;
      end
      chk(n >= 20 && supply_on === 8'hFF, "sequence short");
      chk(mode === PMS_RESET, "no reset state");
      pos(5);
      @(negedge mclk);
      chk(mode === PMS_RESET && i2c_engine_reset === 1'h1, "hold");
      leave_reset();
      @(negedge mclk);
      chk(host_reset_n_out === 1'h1 && int_n_oe === 1'h0, "int");
   endtask : power_up
   initial begin
      pos(6);
      reset_n <= 1'h1;
      @(negedge mclk);
      chk(mode === PMS_NO_POWER && int_n_oe === PMS_OE_OFF, "rst");
      power_up();
      $display("test power_up done");
      host_cmd(2'h0, 12'h000);
      wait_mode(PMS_RESET, 20);
      @(negedge mclk);
      chk(host_reset_n_out === 1'h0, "soft reset");
      leave_reset();
      hw_reset_n_in <= 1'h0;
      pos(10);
      @(negedge mclk);
      chk(host_reset_n_out === 1'h0, "hw reset");
      pos(1);
      hw_reset_n_in <= 1'h1;
      wait_mode(PMS_RESET, 20);
      leave_reset();
      $display("test resets done");
      supply_fault_raw <= 8'h02;
      host_cmd(2'h2, 12'hABC);
      @(negedge mclk);
      chk(int_mask === 12'hABC && mode === PMS_NORMAL, "masked");
      host_cmd(2'h1, 12'h0FE);
      @(negedge mclk);
      chk(pg_mask === 8'hFE && supply_fault === 8'h02, "pg mask");
      pos(1);
      supply_fault_raw <= 8'h03;
      wait_mode(PMS_NO_POWER, 10);
      power_off();
      $display("test pg fault done");
      power_up();
      pos(1);
      thermal_fault <= 1'h1;
      wait_mode(PMS_SLEEP, 10);
      pos(1);
      {thermal_fault, adapter_above_uvlo, usb_above_uvlo} <= 3'h3;
      pos(10);
      {adapter_above_uvlo, usb_above_uvlo} <= 2'h0;
      pos(10);
      usb_above_uvlo <= 1'h1;
      pos(20);
      @(negedge mclk);
      chk(mode === PMS_SLEEP && host_reset_n_out === 1'h0, "sleep");
      power_off();
      $display("test thermal done");
      test_done();
   end
endmodule : tb
`default_nettype wire
